// file: core/dof_consts.svh
/*
 * constants of the drive output function block: register offsets,
 * reset values, function codes, field limits and timing.
 * assumes a 40 MHz clock and a 32-bit APB register bus.
 */
`ifndef DOF_CONSTS_SVH
`define DOF_CONSTS_SVH

`define DOF_CLK_HZ        40000000
`define DOF_FAN_DELAY_S   60

// register byte offsets
`define DOF_A_SEL_RELAY   8'h00
`define DOF_A_SEL_MO1     8'h04
`define DOF_A_SEL_MO2     8'h08
`define DOF_A_SEL_MO3     8'h0C
`define DOF_A_FREQ_ATT1   8'h10
`define DOF_A_FREQ_ATT2   8'h14
`define DOF_A_METER_SRC   8'h18
`define DOF_A_METER_GAIN  8'h1C
`define DOF_A_PULSE_MULT  8'h20
`define DOF_A_TERM_CNT    8'h24
`define DOF_A_PRE_CNT     8'h28
`define DOF_A_CNT_FAULT   8'h2C
`define DOF_A_FAN_MODE    8'h30
`define DOF_A_BRK_REL     8'h34
`define DOF_A_BRK_ENG     8'h38
`define DOF_A_STATUS      8'h3C
`define DOF_A_COUNT       8'h40
`define DOF_A_CTRL        8'h44

// reset values
`define DOF_RST_SEL_RELAY 6'h08
`define DOF_RST_SEL_MO1   6'h01
`define DOF_RST_SEL_MO2   6'h02
`define DOF_RST_SEL_MO3   6'h14
`define DOF_RST_GAIN      8'h64
`define DOF_RST_MULT      5'h01

// output function codes
`define DOF_F_FREQ_ATT1   6'h09
`define DOF_F_TERM_CNT    6'h0E
`define DOF_F_PRE_CNT     6'h0F
`define DOF_F_AUX1        6'h10
`define DOF_F_AUX2        6'h11
`define DOF_F_HEAT_WARN   6'h13
`define DOF_F_READY       6'h14
`define DOF_F_ESTOP       6'h15
`define DOF_F_FREQ_ATT2   6'h16
`define DOF_F_ZERO_SPEED  6'h18
`define DOF_F_UNDER_CUR   6'h19
`define DOF_F_VOLT_OUT    6'h1A
`define DOF_F_FB_ERR      6'h1B
`define DOF_F_LOW_DCBUS   6'h1C
`define DOF_F_BRAKE       6'h1D

// limits
`define DOF_FREQ_MAX      16'h9C40
`define DOF_COUNT_MAX     16'hFFDC
`define DOF_GAIN_MIN      8'h01
`define DOF_GAIN_MAX      8'hC8
`define DOF_MULT_MAX      5'h14
`define DOF_SRC_MAX       3'h5
`define DOF_HEAT_LIMIT_C  8'h55
`define DOF_DISP_LIMIT    16'h2710
`define DOF_METER_FULL    12'hFFF
`define DOF_PCT           7'h64
`define DOF_CENT_HZ       7'h64

// meter sources
`define DOF_SRC_FREQ      3'h0
`define DOF_SRC_CURRENT   3'h1
`define DOF_SRC_VOLT      3'h2
`define DOF_SRC_FCMD      3'h3
`define DOF_SRC_SPEED     3'h4
`define DOF_SRC_PF        3'h5

// fan modes
`define DOF_FAN_ON        2'h0
`define DOF_FAN_DELAY     2'h1
`define DOF_FAN_RUN       2'h2
`define DOF_FAN_HEAT      2'h3

`endif

// file: core/dof_pkg.sv
/*
 * types of the drive output function block.
 * assumes dof_consts.svh holds the numeric constants.
 */
package dof_pkg;
  typedef logic [15:0] dof_freq_t;
  typedef logic [5:0]  dof_code_t;
  typedef logic [31:0] dof_word_t;
  typedef logic [7:0]  dof_addr_t;
  typedef logic [11:0] dof_meter_t;
endpackage

// file: core/dof_top.sv
/*
 * drive output function logic: selectable multi-function outputs, event
 * counter, brake control, pulse and analog meter outputs, fan control,
 * all set up over an APB slave.
 * assumes status and measured values come synchronous from the drive core;
 * frequencies in 0.01 Hz units, temperature in whole degrees C.
 */
`include "dof_consts.svh"

module dof_top #(
  parameter int          CNT_W         = 16,
  parameter longint      FAN_DELAY_CYC = longint'(`DOF_FAN_DELAY_S) * `DOF_CLK_HZ
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // apb slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire dof_pkg::dof_addr_t PADDR_I,
  input  wire dof_pkg::dof_word_t PWDATA_I,
  output dof_pkg::dof_word_t     PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // measured values from the drive core
  input  wire dof_pkg::dof_freq_t OUT_FREQ_I,
  input  wire dof_pkg::dof_freq_t FREQ_CMD_I,
  input  wire dof_pkg::dof_freq_t MAX_FREQ_I,
  input  wire dof_pkg::dof_freq_t MOTOR_SPEED_I,
  input  wire logic [15:0]       OUT_CURRENT_I,
  input  wire logic [15:0]       RATED_CURRENT_I,
  input  wire logic [15:0]       OUT_VOLT_I,
  input  wire logic [15:0]       MAX_VOLT_I,
  input  wire dof_pkg::dof_meter_t POWER_FACTOR_I,
  input  wire logic [7:0]        HEATSINK_TEMP_I,
  // status from the drive core
  input  wire logic              RUN_I,
  input  wire logic              DRIVE_ON_I,
  input  wire logic              FAULT_I,
  input  wire logic              ESTOP_I,
  input  wire logic              UNDER_CURRENT_I,
  input  wire logic              LOW_DCBUS_I,
  input  wire logic              FEEDBACK_ERR_I,
  input  wire logic              VOLT_OUT_I,
  input  wire logic              HEATSINK_PRE_I,
  input  wire logic [1:0]        AUX_MOTOR_I,
  // trigger terminal
  input  wire logic              COUNT_TRIGGER_I,
  // relay and terminal outputs
  output logic                   RELAY_O,
  output logic                   MULTI_OUT_TERMINAL_1_O,
  output logic                   MULTI_OUT_TERMINAL_2_O,
  output logic                   MULTI_OUT_TERMINAL_3_O,
  // meter, pulse, fan, fault
  output dof_pkg::dof_meter_t    ANALOG_METER_OUT_O,
  output logic                   PULSE_FREQ_OUT_O,
  output logic                   FAN_ON_O,
  output logic                   COUNTER_FAULT_MSG_O
);
  import dof_pkg::*;

  generate
    if (CNT_W < 16 || CNT_W > 31) begin : g_bad_cnt
      $error("CNT_W must be 16 to 31");
    end
    if (FAN_DELAY_CYC < 1 || FAN_DELAY_CYC > 64'h0FFFF_FFFF) begin : g_bad_fan
      $error("FAN_DELAY_CYC must be 1 to 2**32-1");
    end
  endgenerate

  localparam logic [CNT_W-1:0] CNT_SAT = {CNT_W{1'b1}};
  localparam logic [31:0] FAN_CYC = 32'(FAN_DELAY_CYC);
  localparam logic [31:0] PULSE_WRAP = 32'(longint'(`DOF_CLK_HZ) * `DOF_CENT_HZ);

  // limit a written value into [lo, hi]
  function automatic logic [15:0] clampv(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
    if (v < lo) begin
      clampv = lo;
    end else if (v > hi) begin
      clampv = hi;
    end else begin
      clampv = v;
    end
  endfunction

  // value * gain / full scale, mapped onto the meter code range
  function automatic dof_meter_t scale(input logic [15:0] v, input logic [17:0] full,
                                       input logic [7:0] gain);
    logic [35:0] num;
    logic [24:0] den;
    logic [35:0] q;
    num = 36'(v) * 36'(gain) * 36'(`DOF_METER_FULL);
    den = 25'(full) * 25'(`DOF_PCT);
    q   = (den == 25'h0) ? 36'h0 : num / 36'(den);
    scale = (q > 36'(`DOF_METER_FULL)) ? `DOF_METER_FULL : q[11:0];
  endfunction

  // registers
  dof_code_t   sel [4];
  dof_freq_t   freq_att1;
  dof_freq_t   freq_att2;
  logic [2:0]  meter_src;
  logic [7:0]  meter_gain;
  logic [4:0]  pulse_mult;
  logic [15:0] term_cnt;
  logic [15:0] pre_cnt;
  logic        cnt_fault_en;
  logic [1:0]  fan_mode;
  dof_freq_t   brk_rel;
  dof_freq_t   brk_eng;

  // internal state
  logic [CNT_W-1:0] count;
  logic             trig_prev;
  logic             cnt_fault;
  logic             brake_on;
  logic [31:0]      fan_timer;
  logic [31:0]      pulse_acc;
  logic [15:0]      disp_val;
  logic             disp_dot;

  logic             wr_en;
  logic             rd_en;
  logic             cnt_clear;
  logic             fault_clear;
  logic             trig_edge;
  logic             term_hit;
  logic             pre_hit;
  logic [3:0]       out_state;
  logic             func_val [4];

  // writes land at the edge where the master sees ready high
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I & ~PREADY_O;
  assign cnt_clear   = wr_en && PADDR_I == `DOF_A_CTRL && PWDATA_I[0];
  assign fault_clear = wr_en && PADDR_I == `DOF_A_CTRL && PWDATA_I[1];

  // register writes
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sel[0]       <= `DOF_RST_SEL_RELAY;
      sel[1]       <= `DOF_RST_SEL_MO1;
      sel[2]       <= `DOF_RST_SEL_MO2;
      sel[3]       <= `DOF_RST_SEL_MO3;
      freq_att1    <= '0;
      freq_att2    <= '0;
      meter_src    <= `DOF_SRC_FREQ;
      meter_gain   <= `DOF_RST_GAIN;
      pulse_mult   <= `DOF_RST_MULT;
      term_cnt     <= '0;
      pre_cnt      <= '0;
      cnt_fault_en <= 1'b0;
      fan_mode     <= `DOF_FAN_ON;
      brk_rel      <= '0;
      brk_eng      <= '0;
    end else if (wr_en) begin
      unique case (PADDR_I)
        `DOF_A_SEL_RELAY:  sel[0] <= PWDATA_I[5:0];
        `DOF_A_SEL_MO1:    sel[1] <= PWDATA_I[5:0];
        `DOF_A_SEL_MO2:    sel[2] <= PWDATA_I[5:0];
        `DOF_A_SEL_MO3:    sel[3] <= PWDATA_I[5:0];
        `DOF_A_FREQ_ATT1:  freq_att1 <= clampv(PWDATA_I[15:0], 16'h0, `DOF_FREQ_MAX);
        `DOF_A_FREQ_ATT2:  freq_att2 <= clampv(PWDATA_I[15:0], 16'h0, `DOF_FREQ_MAX);
        `DOF_A_METER_SRC:  meter_src <= 3'(clampv(16'(PWDATA_I[2:0]), 16'h0, 16'(`DOF_SRC_MAX)));
        `DOF_A_METER_GAIN: meter_gain <= 8'(clampv(16'(PWDATA_I[7:0]), 16'(`DOF_GAIN_MIN),
                                                   16'(`DOF_GAIN_MAX)));
        `DOF_A_PULSE_MULT: pulse_mult <= 5'(clampv(16'(PWDATA_I[4:0]), 16'(`DOF_RST_MULT),
                                                   16'(`DOF_MULT_MAX)));
        `DOF_A_TERM_CNT:   term_cnt <= clampv(PWDATA_I[15:0], 16'h0, `DOF_COUNT_MAX);
        `DOF_A_PRE_CNT:    pre_cnt <= clampv(PWDATA_I[15:0], 16'h0, `DOF_COUNT_MAX);
        `DOF_A_CNT_FAULT:  cnt_fault_en <= PWDATA_I[0];
        `DOF_A_FAN_MODE:   fan_mode <= PWDATA_I[1:0];
        `DOF_A_BRK_REL:    brk_rel <= clampv(PWDATA_I[15:0], 16'h0, `DOF_FREQ_MAX);
        `DOF_A_BRK_ENG:    brk_eng <= clampv(PWDATA_I[15:0], 16'h0, `DOF_FREQ_MAX);
        default: ;
      endcase
    end
  end

  // apb answer: one wait state, error on unmapped offsets
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end else begin
      PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
      PSLVERR_O <= 1'b0;
      if (PSEL_I & PENABLE_I & ~PREADY_O) begin
        PSLVERR_O <= PADDR_I > `DOF_A_CTRL || PADDR_I[1:0] != 2'h0;
      end
      if (rd_en) begin
        PRDATA_O <= '0;
        unique case (PADDR_I)
          `DOF_A_SEL_RELAY:  PRDATA_O <= 32'(sel[0]);
          `DOF_A_SEL_MO1:    PRDATA_O <= 32'(sel[1]);
          `DOF_A_SEL_MO2:    PRDATA_O <= 32'(sel[2]);
          `DOF_A_SEL_MO3:    PRDATA_O <= 32'(sel[3]);
          `DOF_A_FREQ_ATT1:  PRDATA_O <= 32'(freq_att1);
          `DOF_A_FREQ_ATT2:  PRDATA_O <= 32'(freq_att2);
          `DOF_A_METER_SRC:  PRDATA_O <= 32'(meter_src);
          `DOF_A_METER_GAIN: PRDATA_O <= 32'(meter_gain);
          `DOF_A_PULSE_MULT: PRDATA_O <= 32'(pulse_mult);
          `DOF_A_TERM_CNT:   PRDATA_O <= 32'(term_cnt);
          `DOF_A_PRE_CNT:    PRDATA_O <= 32'(pre_cnt);
          `DOF_A_CNT_FAULT:  PRDATA_O <= 32'(cnt_fault_en);
          `DOF_A_FAN_MODE:   PRDATA_O <= 32'(fan_mode);
          `DOF_A_BRK_REL:    PRDATA_O <= 32'(brk_rel);
          `DOF_A_BRK_ENG:    PRDATA_O <= 32'(brk_eng);
          `DOF_A_STATUS:     PRDATA_O <= 32'({disp_dot, FAN_ON_O, brake_on, cnt_fault,
                                              pre_hit, term_hit, out_state});
          `DOF_A_COUNT:      PRDATA_O <= {disp_val, 16'(count)};
          default: ;
        endcase
      end
    end
  end

  // event counter, one step per trigger rising edge, stops at terminal
  assign trig_edge = COUNT_TRIGGER_I & ~trig_prev;
  assign term_hit  = count >= CNT_W'(term_cnt);
  assign pre_hit   = count >= CNT_W'(pre_cnt) && !term_hit;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      trig_prev <= 1'b0;
      count     <= '0;
    end else begin
      trig_prev <= COUNT_TRIGGER_I;
      if (cnt_clear) begin
        count <= '0;
      end else if (trig_edge && !term_hit && count != CNT_SAT) begin
        count <= count + CNT_W'(1);
      end
    end
  end

  // count fault: set while enabled and count >= pre_cnt, which wins over a clear in the same cycle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cnt_fault <= 1'b0;
    end else if (cnt_fault_en && count >= CNT_W'(pre_cnt)) begin
      cnt_fault <= 1'b1;
    end else if (fault_clear) begin
      cnt_fault <= 1'b0;
    end
  end

  // display value: four digits direct, larger counts in tens with a dot
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      disp_val <= '0;
      disp_dot <= 1'b0;
    end else if (count < CNT_W'(`DOF_DISP_LIMIT)) begin
      disp_val <= 16'(count);
      disp_dot <= 1'b0;
    end else begin
      disp_val <= 16'(count / CNT_W'(10));
      disp_dot <= 1'b1;
    end
  end

  // mechanical brake with release / engage hysteresis
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      brake_on <= 1'b0;
    end else if (RUN_I && OUT_FREQ_I >= brk_rel) begin
      brake_on <= 1'b1;
    end else if (!RUN_I && OUT_FREQ_I <= brk_eng) begin
      brake_on <= 1'b0;
    end
  end

  // output function decoding
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (sel[i])
        `DOF_F_FREQ_ATT1:  func_val[i] = OUT_FREQ_I >= freq_att1;
        `DOF_F_FREQ_ATT2:  func_val[i] = OUT_FREQ_I >= freq_att2;
        `DOF_F_TERM_CNT:   func_val[i] = term_hit;
        `DOF_F_PRE_CNT:    func_val[i] = pre_hit;
        `DOF_F_AUX1:       func_val[i] = AUX_MOTOR_I[0];
        `DOF_F_AUX2:       func_val[i] = AUX_MOTOR_I[1];
        `DOF_F_HEAT_WARN:  func_val[i] = HEATSINK_TEMP_I > `DOF_HEAT_LIMIT_C;
        `DOF_F_READY:      func_val[i] = DRIVE_ON_I & ~FAULT_I;
        `DOF_F_ESTOP:      func_val[i] = ESTOP_I;
        `DOF_F_ZERO_SPEED: func_val[i] = OUT_FREQ_I == '0;
        `DOF_F_UNDER_CUR:  func_val[i] = UNDER_CURRENT_I;
        `DOF_F_VOLT_OUT:   func_val[i] = VOLT_OUT_I;
        `DOF_F_FB_ERR:     func_val[i] = FEEDBACK_ERR_I;
        `DOF_F_LOW_DCBUS:  func_val[i] = LOW_DCBUS_I;
        `DOF_F_BRAKE:      func_val[i] = brake_on;
        default:           func_val[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      out_state <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        out_state[i] <= func_val[i];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RELAY_O                <= 1'b0;
      MULTI_OUT_TERMINAL_1_O <= 1'b0;
      MULTI_OUT_TERMINAL_2_O <= 1'b0;
      MULTI_OUT_TERMINAL_3_O <= 1'b0;
      COUNTER_FAULT_MSG_O    <= 1'b0;
    end else begin
      RELAY_O                <= func_val[0];
      MULTI_OUT_TERMINAL_1_O <= func_val[1];
      MULTI_OUT_TERMINAL_2_O <= func_val[2];
      MULTI_OUT_TERMINAL_3_O <= func_val[3];
      COUNTER_FAULT_MSG_O    <= cnt_fault;
    end
  end

  // pulse output: two toggles per period of frequency times factor
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pulse_acc        <= '0;
      PULSE_FREQ_OUT_O <= 1'b0;
    end else if (pulse_acc + 32'(OUT_FREQ_I) * 32'(pulse_mult) * 32'h2 >= PULSE_WRAP) begin
      pulse_acc        <= pulse_acc + 32'(OUT_FREQ_I) * 32'(pulse_mult) * 32'h2 - PULSE_WRAP;
      PULSE_FREQ_OUT_O <= ~PULSE_FREQ_OUT_O;
    end else begin
      pulse_acc <= pulse_acc + 32'(OUT_FREQ_I) * 32'(pulse_mult) * 32'h2;
    end
  end

  // analog meter source and gain
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ANALOG_METER_OUT_O <= '0;
    end else begin
      unique case (meter_src)
        `DOF_SRC_FREQ:    ANALOG_METER_OUT_O <= scale(OUT_FREQ_I, 18'(MAX_FREQ_I), meter_gain);
        `DOF_SRC_CURRENT: ANALOG_METER_OUT_O <= scale(OUT_CURRENT_I,
                                                      18'((19'(RATED_CURRENT_I) * 19'h5) >> 1),
                                                      meter_gain);
        `DOF_SRC_VOLT:    ANALOG_METER_OUT_O <= scale(OUT_VOLT_I, 18'(MAX_VOLT_I), meter_gain);
        `DOF_SRC_FCMD:    ANALOG_METER_OUT_O <= scale(FREQ_CMD_I, 18'(MAX_FREQ_I), meter_gain);
        `DOF_SRC_SPEED:   ANALOG_METER_OUT_O <= scale(MOTOR_SPEED_I, 18'(MAX_FREQ_I), meter_gain);
        `DOF_SRC_PF:      ANALOG_METER_OUT_O <= scale(16'(POWER_FACTOR_I), 18'(`DOF_METER_FULL),
                                                      meter_gain);
        default:          ANALOG_METER_OUT_O <= '0;
      endcase
    end
  end

  // fan control
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      fan_timer <= '0;
      FAN_ON_O  <= 1'b1;
    end else begin
      unique case (fan_mode)
        `DOF_FAN_ON: begin
          FAN_ON_O <= 1'b1;
        end
        `DOF_FAN_DELAY: begin
          if (RUN_I) begin
            fan_timer <= FAN_CYC;
            FAN_ON_O  <= 1'b1;
          end else if (fan_timer != '0) begin
            fan_timer <= fan_timer - 32'h1;
            FAN_ON_O  <= 1'b1;
          end else begin
            FAN_ON_O <= 1'b0;
          end
        end
        `DOF_FAN_RUN: begin
          FAN_ON_O <= RUN_I;
        end
        `DOF_FAN_HEAT: begin
          FAN_ON_O <= HEATSINK_PRE_I;
        end
      endcase
    end
  end

endmodule

// file: bench/dof_chk.sv
/*
 * port checker for dof_top, bound to the top module.
 * assumes one clock, synchronous active-high reset and the apb timing of the notes.
 */
module dof_chk (
  // clock and reset
  input wire logic                CLK_I,
  input wire logic                RST_I,
  // apb
  input wire logic                PSEL_I,
  input wire logic                PENABLE_I,
  input wire logic                PWRITE_I,
  input wire dof_pkg::dof_addr_t  PADDR_I,
  input wire dof_pkg::dof_word_t  PRDATA_O,
  input wire logic                PREADY_O,
  input wire logic                PSLVERR_O,
  // drive side
  input wire dof_pkg::dof_freq_t  OUT_FREQ_I,
  input wire logic                RELAY_O,
  input wire logic                PULSE_FREQ_OUT_O,
  input wire logic                FAN_ON_O,
  input wire logic                COUNTER_FAULT_MSG_O
);
  import dof_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire acc = PSEL_I && PENABLE_I && !PREADY_O;
  wire bad = PADDR_I > 8'h44 || PADDR_I[1:0] != 2'h0;
  rdy_after_acc_a: assert property (acc |=> PREADY_O)
    else $error("no ready after access");
  rdy_one_cycle_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready too long");
  rdy_has_cause_a: assert property (PREADY_O |-> $past(acc))
    else $error("ready without access");
  err_unmapped_a: assert property (acc && bad |=> PSLVERR_O && PREADY_O)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (acc && !bad |=> !PSLVERR_O)
    else $error("error on mapped address");
  err_read_zero_a: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  fault_sticky_a: assert property (COUNTER_FAULT_MSG_O && !PSEL_I && !$past(PSEL_I) |=> COUNTER_FAULT_MSG_O)
    else $error("fault dropped without clear");
  reset_out_a: assert property ($fell(RST_I) |-> FAN_ON_O && !RELAY_O && !COUNTER_FAULT_MSG_O && !PULSE_FREQ_OUT_O)
    else $error("bad output after reset");
  pulse_idle_a: assert property ((OUT_FREQ_I == 16'h0000) [*3] |=> $stable(PULSE_FREQ_OUT_O))
    else $error("pulse moves at zero frequency");
  cover property (acc && bad);
  cover property ($rose(COUNTER_FAULT_MSG_O));
  cover property ($rose(PULSE_FREQ_OUT_O));
endmodule
bind dof_top dof_chk u_chk (.CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O,
  .PSLVERR_O, .OUT_FREQ_I, .RELAY_O, .PULSE_FREQ_OUT_O, .FAN_ON_O, .COUNTER_FAULT_MSG_O);

// file: bench/dof_trig_src.sv
/*
 * far side model: trigger terminal source and pulse output edge counter.
 * assumes the device clock; trigger idles low between bursts.
 */
module dof_trig_src (
  // clock and control
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic [31:0] n_i,
  // device pins and bench status
  input  wire logic pulse_i,
  output logic      trig_o,
  output logic      busy_o,
  output int        edges_o
);
  int left = 0;
  int cnt_e = 0;
  logic [1:0] ph = 2'h0;
  logic last = 1'b0;
  assign trig_o = ph[1];
  assign busy_o = left != 0;
  assign edges_o = cnt_e;
  // each pulse two cycles high, two low
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      left <= n_i;
    end else if (left != 0) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) left <= left - 1;
    end
  end
  always_ff @(posedge clk_i) begin
    last <= pulse_i;
    cnt_e <= cnt_e + int'(last != pulse_i);
  end
endmodule

// file: bench/tb_top.sv
/*
 * self-checking bench for dof_top against a reference model.
 * assumes dof_pkg, dof_top, dof_trig_src and dof_chk compiled first.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dof_pkg::*;
  localparam int FD = 20;
  localparam int RA[8] = '{0, 4, 8, 12, 28, 32, 16, 36}, RV[8] = '{8, 1, 2, 20, 100, 1, 0, 0};
  localparam int CA[9] = '{16, 52, 36, 40, 28, 28, 32, 32, 24};
  localparam int CW[9] = '{50000, 40000, 65535, 65500, 0, 250, 25, 0, 7};
  localparam int CE[9] = '{40000, 40000, 65500, 65500, 1, 200, 20, 1, 5};
  localparam int CL[16] = '{9, 16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 0, 13};
  localparam int XS[6] = '{0, 4, 6, 1, 3, 0};
  localparam int FM[5] = '{0, 2, 2, 3, 3}, FS[5] = '{0, 0, 1, 0, 256}, FE[5] = '{1, 0, 1, 0, 1};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
  dof_addr_t paddr = 8'h00;
  dof_word_t pwdata = 32'h0, prdata, rd_v;
  logic pready, perr, rd_e, trig, busy, pout, fan, cfault;
  logic [3:0] outs;
  dof_meter_t meter, pf = 12'h000;
  dof_freq_t v[8] = '{default: 16'h0000};
  logic [7:0] temp = 8'h00;
  logic [10:0] st = 11'h000;
  int np = 0, edges, e0, g, cyc = 0, miscompares = 0, compares = 0;
  int att1 = 100, att2 = 100, term = 0, pre = 0, cnt = 0, sel[4];
  longint pe;
  bit brk = 0;
  int unsigned seed = 12;
  dof_top #(.CNT_W(16), .FAN_DELAY_CYC(FD)) uut (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .OUT_FREQ_I(v[0]),
    .FREQ_CMD_I(v[1]), .MAX_FREQ_I(v[2]), .MOTOR_SPEED_I(v[3]), .OUT_CURRENT_I(v[4]), .RATED_CURRENT_I(v[5]),
    .OUT_VOLT_I(v[6]), .MAX_VOLT_I(v[7]), .POWER_FACTOR_I(pf), .HEATSINK_TEMP_I(temp), .RUN_I(st[0]),
    .DRIVE_ON_I(st[1]), .FAULT_I(st[2]), .ESTOP_I(st[3]), .UNDER_CURRENT_I(st[4]), .LOW_DCBUS_I(st[5]),
    .FEEDBACK_ERR_I(st[6]), .VOLT_OUT_I(st[7]), .HEATSINK_PRE_I(st[8]), .AUX_MOTOR_I(st[10:9]),
    .COUNT_TRIGGER_I(trig), .RELAY_O(outs[0]), .MULTI_OUT_TERMINAL_1_O(outs[1]), .MULTI_OUT_TERMINAL_2_O(outs[2]),
    .MULTI_OUT_TERMINAL_3_O(outs[3]), .ANALOG_METER_OUT_O(meter), .PULSE_FREQ_OUT_O(pout), .FAN_ON_O(fan),
    .COUNTER_FAULT_MSG_O(cfault));
  dof_trig_src src (.clk_i(clk), .go_i(go), .n_i(np), .pulse_i(pout), .trig_o(trig), .busy_o(busy),
    .edges_o(edges));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      summarize();
    end
  end
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic fn(int c);
    case (c)
      9: return v[0] >= att1;
      22: return v[0] >= att2;
      14: return cnt >= term;
      15: return cnt >= pre && cnt < term;
      16: return st[9];
      17: return st[10];
      19: return temp > 85;
      20: return st[1] && !st[2];
      21: return st[3];
      24: return v[0] == 0;
      25: return st[4];
      26: return st[7];
      27: return st[6];
      28: return st[5];
      29: return brk;
      default: return 1'b0;
    endcase
  endfunction
  function automatic longint mexp(int s, int gn);
    longint x, f;
    x = s == 5 ? longint'(pf) : longint'(v[XS[s]]);
    f = s == 5 ? 4095 : s == 1 ? longint'(v[5]) * 5 / 2 : longint'(v[s == 2 ? 7 : 2]);
    if (f == 0) return 0;
    x = x * gn * 4095 / (f * 100);
    return x > 4095 ? 4095 : x;
  endfunction
  task automatic check(input dof_word_t s, input dof_word_t e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input dof_addr_t a, input logic w, input int d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input int a, input int d);
    apb(8'(a), 1'b1, d);
  endtask
  task automatic rd(input int a);
    apb(8'(a), 1'b0, 0);
  endtask
  task automatic hold();
    repeat (2) @(posedge clk);
  endtask
  task automatic setsel();
    for (int k = 0; k < 4; k++) wr(4 * k, sel[k]);
  endtask
  task automatic chk_outs();
    check(32'(outs), 32'({fn(sel[3]), fn(sel[2]), fn(sel[1]), fn(sel[0])}));
  endtask
  task automatic stim();
    @(posedge clk);
    st <= 11'(rnd());
    temp <= 8'(80 + rnd() % 10);
    pf <= 12'(rnd());
    for (int k = 1; k < 8; k++) v[k] <= 16'(rnd() & (k == 5 ? 32'hFFFE : 32'hFFFF));
    v[0] <= rnd() % 5 == 0 ? 16'h0000 : 16'((rnd() % 2 ? att1 : att2) + rnd() % 16 - 8);
  endtask
  task automatic pulses(input int n);
    @(posedge clk);
    np <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'({fan, outs, pout, cfault, meter}), 32'h0004_0000);
    for (int i = 0; i < 8; i++) begin
      rd(RA[i]);
      check(rd_v, RV[i]);
    end
    rd(8'h48);
    check({rd_v[30:0], rd_e}, 32'h1);
    rd(8'h02);
    check({rd_v[30:0], rd_e}, 32'h1);
    for (int i = 0; i < 9; i++) begin
      wr(CA[i], CW[i]);
      rd(CA[i]);
      check(rd_v, CE[i]);
    end
    for (int i = 0; i < 24; i++) begin
      att1 = 100 + rnd() % 39900;
      att2 = 100 + rnd() % 39900;
      wr(8'h10, att1);
      wr(8'h14, att2);
      for (int k = 0; k < 4; k++) sel[k] = CL[(i + 5 * k) % 16];
      setsel();
      repeat (4) begin
        stim();
        hold();
        chk_outs();
      end
    end
    term = 5;
    pre = 3;
    wr(8'h24, term);
    wr(8'h28, pre);
    wr(8'h2C, 1);
    wr(8'h44, 3);
    sel = '{0, 15, 14, 0};
    setsel();
    for (int k = 0; k < 8; k++) begin
      pulses(1);
      cnt = cnt < term ? cnt + 1 : cnt;
      chk_outs();
      rd(8'h40);
      check(rd_v, cnt << 16 | cnt);
      check(32'(cfault), 32'(cnt >= pre));
    end
    wr(8'h44, 2);
    hold();
    check(32'(cfault), 1);
    wr(8'h44, 1);
    wr(8'h44, 2);
    wr(8'h2C, 0);
    pulses(4);
    check(32'(cfault), 0);
    term = 65500;
    wr(8'h24, term);
    wr(8'h44, 1);
    pulses(10001);
    cnt = 10001;
    chk_outs();
    rd(8'h40);
    check(rd_v, 1000 << 16 | cnt);
    rd(8'h3C);
    check(32'(rd_v[9]), 1);
    wr(8'h34, 1000);
    wr(8'h38, 500);
    sel = '{29, 29, 29, 29};
    setsel();
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      st[0] <= i == 0 ? 1'b0 : 1'(rnd());
      v[0] <= i == 0 ? 16'h0000 : 16'(rnd() % 1500);
      hold();
      @(posedge clk);
      if (st[0] && v[0] >= 1000) brk = 1; else if (!st[0] && v[0] <= 500) brk = 0;
      chk_outs();
    end
    for (int i = 0; i < 18; i++) begin
      g = 1 + rnd() % 200;
      wr(8'h18, i % 6);
      wr(8'h1C, g);
      stim();
      hold();
      check(32'(meter), 32'(mexp(i % 6, g)));
    end
    wr(8'h20, 20);
    @(posedge clk);
    v[0] <= 16'h9C40;
    repeat (10) @(posedge clk);
    e0 = edges;
    repeat (20000) @(posedge clk);
    pe = 64'd20000 * 2 * 40000 * 20 / 64'd4000000000;
    check(32'(edges - e0 >= pe - 1 && edges - e0 <= pe + 1), 1);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      st <= 11'(FS[i]);
      v[0] <= 16'h0000;
      wr(8'h30, FM[i]);
      hold();
      check(32'(fan), FE[i]);
    end
    @(posedge clk);
    st <= 11'h001;
    wr(8'h30, 1);
    hold();
    check(32'(fan), 1);
    @(posedge clk);
    st <= 11'h000;
    repeat (FD / 2) @(posedge clk);
    check(32'(fan), 1);
    repeat (FD + 4) @(posedge clk);
    check(32'(fan), 0);
    summarize();
  end
endmodule
